// ---- design/ivm_pkg.sv ----
/*
 Constants, source table and carrier types for the interrupt vector mapper.
 Assumes a 16-bit register port with 5-bit word addresses and one system clock.
*/
// Behaviour
// - External interrupt zero: vector 8, IRQ 0, entry 0x000014, word0 bit0, prio0 2:0
// - Input capture one: vector 9, IRQ 1, entry 0x000016, word0 bit1, prio0 6:4
// - SPI1 transfer done: vector 18, IRQ 10, entry 0x000028, word0 bit10, prio2 10:8
// - UART1 receive: vector 19, IRQ 11, entry 0x00002A, word0 bit11, prio2 14:12
// - UART1 transmit: vector 20, IRQ 12, entry 0x00002C, word0 bit12, prio3 2:0
// - ADC1 done: vector 21, IRQ 13, entry 0x00002E, word0 bit13, prio3 6:4
// - I2C1 slave: vector 24, IRQ 16, entry 0x000034, word1 bit0, prio4 2:0
// - I2C1 master: vector 25, IRQ 17, entry 0x000036, word1 bit1, prio4 6:4
// - Comparator combined: vector 26, IRQ 18, entry 0x000038, word1 bit2, prio4 10:8
// - Pin change: vector 27, IRQ 19, entry 0x00003A, word1 bit3, prio4 14:12
// - External interrupt one: vector 28, entry 0x00003C, word1 bit4; vectors 29-31 reserved
// - DMA channel two: vector 32, IRQ 24, entry 0x000044, word1 bit8, prio6 2:0
// - External interrupt two: vector 37, IRQ 29, entry 0x00004E, word1 bit13, prio7 6:4
// - UART2 receive: vector 38, IRQ 30, entry 0x000050, word1 bit14, prio7 10:8
// - CAN1 receive ready, CAN variants only: vector 42, IRQ 34, entry 0x000058, word2 bit2
// - I2C2 slave: vector 57, IRQ 49, entry 0x000076, word3 bit1, prio12 6:4
// - PWM special match, motor variants only: vector 65, IRQ 57, entry 0x000086, word3 bit9
// - Sleep stops the clock and halts code until a wake-up condition
// - Idle halts the processor; peripherals keep running and raising requests
// - Sleep or Idle ends on enabled interrupt, watchdog time-out or reset
package ivm_pkg;
   localparam int IVM_NSRC = 17;
   localparam int IVM_PW = 3;
   localparam logic [4:0] IVM_FLAG_BASE = 5'h00;
   localparam logic [4:0] IVM_EN_BASE = 5'h04;
   localparam logic [4:0] IVM_PRIO_BASE = 5'h08;
   localparam logic [4:0] IVM_STAT_ADDR = 5'h17;
   localparam logic [4:0] IVM_LAST_ADDR = 5'h18;
   localparam logic [2:0] IVM_PRIO_RST = 3'h4;
   localparam logic [2:0] IVM_PRIO_OFF = 3'h0;
   localparam int IVM_SRC_CAN = 14;
   localparam int IVM_SRC_PWM = 16;
   // Status word layout
   localparam int IVM_ST_VEC_LSB = 0;
   localparam int IVM_ST_VALID = 7;
   localparam int IVM_ST_MODE_LSB = 8;

   typedef struct packed {
      logic [6:0] vec;
      logic [5:0] irq;
      logic [23:0] entry;
      logic [1:0] word;
      logic [3:0] bitpos;
      logic [3:0] preg;
      logic [3:0] plsb;
   } ivm_src_t;

   localparam ivm_src_t IVM_SRC [IVM_NSRC] = '{
      '{7'h08, 6'h00, 24'h000014, 2'h0, 4'h0, 4'h0, 4'h0},
      '{7'h09, 6'h01, 24'h000016, 2'h0, 4'h1, 4'h0, 4'h4},
      '{7'h12, 6'h0a, 24'h000028, 2'h0, 4'ha, 4'h2, 4'h8},
      '{7'h13, 6'h0b, 24'h00002a, 2'h0, 4'hb, 4'h2, 4'hc},
      '{7'h14, 6'h0c, 24'h00002c, 2'h0, 4'hc, 4'h3, 4'h0},
      '{7'h15, 6'h0d, 24'h00002e, 2'h0, 4'hd, 4'h3, 4'h4},
      '{7'h18, 6'h10, 24'h000034, 2'h1, 4'h0, 4'h4, 4'h0},
      '{7'h19, 6'h11, 24'h000036, 2'h1, 4'h1, 4'h4, 4'h4},
      '{7'h1a, 6'h12, 24'h000038, 2'h1, 4'h2, 4'h4, 4'h8},
      '{7'h1b, 6'h13, 24'h00003a, 2'h1, 4'h3, 4'h4, 4'hc},
      '{7'h1c, 6'h14, 24'h00003c, 2'h1, 4'h4, 4'h5, 4'h0},
      '{7'h20, 6'h18, 24'h000044, 2'h1, 4'h8, 4'h6, 4'h0},
      '{7'h25, 6'h1d, 24'h00004e, 2'h1, 4'hd, 4'h7, 4'h4},
      '{7'h26, 6'h1e, 24'h000050, 2'h1, 4'he, 4'h7, 4'h8},
      '{7'h2a, 6'h22, 24'h000058, 2'h2, 4'h2, 4'h8, 4'h8},
      '{7'h39, 6'h31, 24'h000076, 2'h3, 4'h1, 4'hc, 4'h4},
      '{7'h41, 6'h39, 24'h000086, 2'h3, 4'h9, 4'he, 4'h4}
   };

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic we;
      logic re;
   } ivm_bus_t;

   typedef struct packed {
      logic valid;
      logic [6:0] vec;
      logic [5:0] irq;
      logic [23:0] entry;
      logic [2:0] prio;
   } ivm_vec_t;

   typedef enum logic [1:0] {IVM_RUN, IVM_IDLE, IVM_SLEEP} ivm_pwr_t;
endpackage

// ---- design/ivm_prio_pick.sv ----
/*
 Priority picker: chooses the pending source with the highest priority.
 Assumes sources are indexed in rising vector order.
*/
`timescale 1ns/10ps
module ivm_prio_pick (
   input wire logic [ivm_pkg::IVM_NSRC-1:0] req, // Pending and enabled sources
   input wire logic [2:0] prio [ivm_pkg::IVM_NSRC], // Programmed priority per source
   output logic found, // Some source pending
   output logic [4:0] idx // Index of the winner
);
   import ivm_pkg::*;

   logic [2:0] best;

   always_comb begin
      found = 1'b0;
      idx = 5'h00;
      best = IVM_PRIO_OFF;
      // Ascending scan with a strict compare keeps the lowest vector on a tie
      for (int i = 0; i < IVM_NSRC; i++) begin
         if (req[i] && (!found || prio[i] > best)) begin
            found = 1'b1;
            idx = 5'(i);
            best = prio[i];
         end
      end
   end
endmodule

// ---- design/ivm_mapper.sv ----
/*
 Interrupt vector mapper: per-source flag, enable and priority state, vector
 selection for the core, and the Sleep and Idle wake-up logic.
 Assumes single-cycle peripheral request pulses synchronous to sys_clk and a
 register master that never needs wait states.
*/
`timescale 1ns/10ps
module ivm_mapper #(
   parameter bit HAS_CAN = 1'b1, // CAN receive source present
   parameter bit HAS_PWM = 1'b1 // PWM special match source present
) (
   input wire logic sys_clk, // System clock, 125 MHz
   input wire logic nrst, // Asynchronous reset, active low
   input wire ivm_pkg::ivm_bus_t bus, // Register port request
   output logic [15:0] rdata, // Read data, cycle after the read strobe
   input wire logic [ivm_pkg::IVM_NSRC-1:0] src_req, // Peripheral request pulses
   input wire logic pwr_cmd, // Power-save instruction executed
   input wire logic pwr_sleep, // With pwr_cmd: 1 Sleep, 0 Idle
   input wire logic wdt_timeout, // Watchdog time-out pulse
   input wire logic vec_taken, // Core took the presented vector
   output ivm_pkg::ivm_vec_t vec_out, // Vector offered to the core
   output logic cpu_halt, // Processor halted
   output logic clk_stop, // System clocks stopped
   output logic wake // One-cycle wake-up pulse
);
   import ivm_pkg::*;

   logic [IVM_NSRC-1:0] impl;
   logic [IVM_NSRC-1:0] flag;
   logic [IVM_NSRC-1:0] enable;
   logic [2:0] prio [IVM_NSRC];
   logic [IVM_NSRC-1:0] active;
   logic [IVM_NSRC-1:0] pending;
   logic pick_found;
   logic [4:0] pick_idx;
   ivm_pwr_t mode;
   ivm_pwr_t next_mode;
   logic wake_cond;
   logic [6:0] last_vec;
   logic [15:0] next_rdata;

   // Register address match for a word of a group
   function automatic logic hit(input logic [4:0] a, input logic [4:0] base, input logic [3:0] n);
      return a == 5'(base + {1'b0, n});
   endfunction

   // Absent variant sources keep no state; reserved vectors have no entry at all
   always_comb begin
      impl = '1;
      impl[IVM_SRC_CAN] = HAS_CAN;
      impl[IVM_SRC_PWM] = HAS_PWM;
   end

   // Flags: a peripheral pulse in the same cycle as a software clear wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flag <= '0;
      end else begin
         for (int i = 0; i < IVM_NSRC; i++) begin
            if (bus.we && hit(bus.addr, IVM_FLAG_BASE, {2'h0, IVM_SRC[i].word})) begin
               flag[i] <= impl[i] & (bus.wdata[IVM_SRC[i].bitpos] | src_req[i]);
            end else begin
               flag[i] <= impl[i] & (flag[i] | src_req[i]);
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         enable <= '0;
      end else begin
         for (int i = 0; i < IVM_NSRC; i++) begin
            if (bus.we && hit(bus.addr, IVM_EN_BASE, {2'h0, IVM_SRC[i].word})) begin
               enable[i] <= impl[i] & bus.wdata[IVM_SRC[i].bitpos];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < IVM_NSRC; i++) begin
            prio[i] <= IVM_PRIO_RST;
         end
      end else begin
         for (int i = 0; i < IVM_NSRC; i++) begin
            if (bus.we && impl[i] && hit(bus.addr, IVM_PRIO_BASE, IVM_SRC[i].preg)) begin
               prio[i] <= bus.wdata[IVM_SRC[i].plsb +: IVM_PW];
            end
         end
      end
   end

   // Priority zero takes a source out of vectoring but it can still wake the core
   always_comb begin
      for (int i = 0; i < IVM_NSRC; i++) begin
         active[i] = flag[i] & enable[i];
         pending[i] = active[i] & (prio[i] != IVM_PRIO_OFF);
      end
   end

   ivm_prio_pick u_pick (
      .req(pending),
      .prio(prio),
      .found(pick_found),
      .idx(pick_idx)
   );

   // Vector is only offered while the core runs; flags keep collecting meanwhile
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         vec_out <= '0;
      end else if (pick_found && mode == IVM_RUN) begin
         vec_out.valid <= 1'b1;
         vec_out.vec <= IVM_SRC[pick_idx].vec;
         vec_out.irq <= IVM_SRC[pick_idx].irq;
         vec_out.entry <= IVM_SRC[pick_idx].entry;
         vec_out.prio <= prio[pick_idx];
      end else begin
         vec_out <= '0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         last_vec <= 7'h00;
      end else if (vec_taken && vec_out.valid) begin
         last_vec <= vec_out.vec;
      end
   end

   assign wake_cond = (|active) | wdt_timeout;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         IVM_RUN: begin
            if (pwr_cmd) begin
               next_mode = pwr_sleep ? IVM_SLEEP : IVM_IDLE;
            end
         end
         IVM_IDLE: begin
            if (wake_cond) begin
               next_mode = IVM_RUN;
            end
         end
         IVM_SLEEP: begin
            if (wake_cond) begin
               next_mode = IVM_RUN;
            end
         end
         default: begin
            next_mode = IVM_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= IVM_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_halt <= 1'b0;
         clk_stop <= 1'b0;
         wake <= 1'b0;
      end else begin
         cpu_halt <= next_mode != IVM_RUN;
         clk_stop <= next_mode == IVM_SLEEP;
         wake <= mode != IVM_RUN && next_mode == IVM_RUN;
      end
   end

   // Read mux; unmapped addresses and unimplemented bits read as zero
   always_comb begin
      next_rdata = 16'h0000;
      for (int i = 0; i < IVM_NSRC; i++) begin
         if (hit(bus.addr, IVM_FLAG_BASE, {2'h0, IVM_SRC[i].word})) begin
            next_rdata[IVM_SRC[i].bitpos] = flag[i];
         end
         if (hit(bus.addr, IVM_EN_BASE, {2'h0, IVM_SRC[i].word})) begin
            next_rdata[IVM_SRC[i].bitpos] = enable[i];
         end
         if (impl[i] && hit(bus.addr, IVM_PRIO_BASE, IVM_SRC[i].preg)) begin
            next_rdata[IVM_SRC[i].plsb +: IVM_PW] = prio[i];
         end
      end
      if (bus.addr == IVM_STAT_ADDR) begin
         next_rdata[IVM_ST_VEC_LSB +: 7] = pick_found ? IVM_SRC[pick_idx].vec : 7'h00;
         next_rdata[IVM_ST_VALID] = pick_found;
         next_rdata[IVM_ST_MODE_LSB +: 2] = mode;
      end
      if (bus.addr == IVM_LAST_ADDR) begin
         next_rdata[IVM_ST_VEC_LSB +: 7] = last_vec;
      end
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (bus.re) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule

// ---- verif/ivm_mapper_sva.sv ----
/*
 Port assertions for the interrupt vector mapper.
 Binds into every ivm_mapper instance, here the testbench DUT; the bind follows the checker.
*/
`timescale 1ns/10ps
module ivm_mapper_sva (
   input wire logic sys_clk, // System clock
   input wire logic nrst, // Reset, active low
   input wire ivm_pkg::ivm_bus_t bus, // Register request
   input wire logic [15:0] rdata, // Read data
   input wire logic [ivm_pkg::IVM_NSRC-1:0] src_req, // Request pulses
   input wire logic pwr_cmd, // Power-save command
   input wire logic pwr_sleep, // Sleep select
   input wire logic wdt_timeout, // Watchdog time-out
   input wire logic vec_taken, // Core took vector
   input wire ivm_pkg::ivm_vec_t vec_out, // Offered vector
   input wire logic cpu_halt, // Processor halted
   input wire logic clk_stop, // Clocks stopped
   input wire logic wake // Wake pulse
);
   import ivm_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence sleep_cmd;
      pwr_cmd && pwr_sleep && !cpu_halt;
   endsequence
   sequence wake_seq;
      !cpu_halt && !clk_stop && wake ##1 !wake;
   endsequence
   vec_map_a: assert property (vec_out.valid |->
      vec_out.irq == 6'(vec_out.vec - 7'h08) && vec_out.entry == 24'h4 + {16'h0, vec_out.vec, 1'b0})
      else $error("irq or entry does not match vector");
   vec_rsv_a: assert property (vec_out.valid |->
      vec_out.vec inside {8, 9, 18, 19, 20, 21, 24, 25, 26, 27, 28, 32, 37, 38, 42, 57, 65})
      else $error("unmapped vector offered");
   prio_nz_a: assert property (vec_out.valid |-> vec_out.prio != 3'h0) else $error("priority zero offered");
   halt_novec_a: assert property (cpu_halt |=> !vec_out.valid) else $error("vector offered while halted");
   sleep_in_a: assert property (sleep_cmd |=> cpu_halt && clk_stop) else $error("sleep not entered");
   idle_in_a: assert property (pwr_cmd && !pwr_sleep && !cpu_halt |=> cpu_halt && !clk_stop)
      else $error("idle not entered");
   wdt_wake_a: assert property (cpu_halt && wdt_timeout |=> wake_seq) else $error("no wake on time-out");
   wake_fall_a: assert property ($fell(cpu_halt) |-> wake) else $error("halt left without wake");
   stop_halt_a: assert property (clk_stop |-> cpu_halt) else $error("clock stopped while running");
endmodule

bind ivm_mapper ivm_mapper_sva chk (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .src_req(src_req),
   .pwr_cmd(pwr_cmd), .pwr_sleep(pwr_sleep), .wdt_timeout(wdt_timeout), .vec_taken(vec_taken), .vec_out(vec_out),
   .cpu_halt(cpu_halt), .clk_stop(clk_stop), .wake(wake));

// ---- verif/ivm_core_model.sv ----
/*
 Behavioural core: takes each offered vector once, promptly or after a delay.
 Assumes the mapper withdraws its offer when the flag is cleared.
*/
`timescale 1ns/10ps
module ivm_core_model (
   input wire logic sys_clk, // System clock
   input wire logic nrst, // Reset, active low
   input wire logic vec_valid, // Vector offered
   input wire logic slow, // Long acceptance delay
   output logic vec_taken // Vector taken pulse
);
   logic [2:0] wait_cnt;
   logic done;
   // A halted core cannot acknowledge; the mapper withdraws its offer then
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wait_cnt <= 3'h0;
         done <= 1'b0;
         vec_taken <= 1'b0;
      end else begin
         vec_taken <= 1'b0;
         if (!vec_valid) begin
            wait_cnt <= 3'h0;
            done <= 1'b0;
         end else if (!done && wait_cnt == (slow ? 3'h3 : 3'h0)) begin
            vec_taken <= 1'b1;
            done <= 1'b1;
         end else if (!done) begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end
endmodule

// ---- verif/testbench.sv ----
/*
 Self-checking bench for the interrupt vector mapper.
 Assumes the core model and the bound checker.
*/
`timescale 1ns/10ps
module testbench;
   import ivm_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   ivm_bus_t bus = '0;
   logic [IVM_NSRC-1:0] src_req = '0;
   logic pwr_cmd = 1'b0, pwr_sleep = 1'b0, wdt_timeout = 1'b0, slow = 1'b0, rd_d = 1'b0, v_d = 1'b0;
   logic vec_taken, cpu_halt, clk_stop, wake;
   logic [15:0] rdata;
   logic [9:0] ev;
   ivm_vec_t vec_out;
   int err_total = 0, cmp_count = 0, cyc = 0;
   logic [15:0] rq [$];
   // Each note holds the expected priority above the expected vector
   logic [9:0] vq [$];
   int vt [IVM_NSRC] = '{8, 9, 18, 19, 20, 21, 24, 25, 26, 27, 28, 32, 37, 38, 42, 57, 65};
   logic [15:0] impl [4] = '{16'h3c03, 16'h611f, 16'h0004, 16'h0202};
   always #4 sys_clk = ~sys_clk;
   ivm_mapper DUT (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .src_req(src_req), .pwr_cmd(pwr_cmd),
      .pwr_sleep(pwr_sleep), .wdt_timeout(wdt_timeout), .vec_taken(vec_taken), .vec_out(vec_out),
      .cpu_halt(cpu_halt), .clk_stop(clk_stop), .wake(wake));
   ivm_core_model core (.sys_clk(sys_clk), .nrst(nrst), .vec_valid(vec_out.valid), .slow(slow), .vec_taken(vec_taken));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Each access leaves an idle cycle so the strobe is never driven twice at one edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge sys_clk);
      bus <= '0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      rq.push_back(exp);
      bus <= '{addr: a, wdata: 16'h0, we: 1'b0, re: 1'b1};
      @(posedge sys_clk);
      bus <= '0;
      @(posedge sys_clk);
   endtask
   task automatic pulse_src(input logic [IVM_NSRC-1:0] m);
      src_req <= m;
      @(posedge sys_clk);
      src_req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic one_src(input int i, input logic [2:0] p);
      ivm_src_t s;
      s = IVM_SRC[i];
      wr(IVM_EN_BASE + 5'(s.word), 16'h1 << s.bitpos);
      wr(IVM_PRIO_BASE + 5'(s.preg), 16'(p) << s.plsb);
      if (p != 3'h0)
         vq.push_back({p, 7'(vt[i])});
      pulse_src(IVM_NSRC'(1) << i);
      repeat (3) @(posedge sys_clk);
      wr(IVM_FLAG_BASE + 5'(s.word), 16'h0);
      wr(IVM_EN_BASE + 5'(s.word), 16'h0);
   endtask
   always @(posedge sys_clk) begin
      if (rd_d)
         check("rdata", rq.pop_front(), rdata);
      if (vec_out.valid && !v_d) begin
         ev = vq.pop_front();
         check("vector", ev[6:0], vec_out.vec);
         check("irq", ev[6:0] - 7'h08, vec_out.irq);
         check("entry", 24'h4 + 2 * ev[6:0], vec_out.entry);
         check("prio", ev[9:7], vec_out.prio);
      end
      rd_d <= bus.re;
      v_d <= vec_out.valid;
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'hfcfbfcc1));
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd(IVM_PRIO_BASE, 16'h0044);
      rd(5'h09, 16'h0);
      rd(5'h1f, 16'h0);
      for (int w = 0; w < 4; w++) begin
         wr(IVM_EN_BASE + 5'(w), 16'hffff);
         rd(IVM_EN_BASE + 5'(w), impl[w]);
         wr(IVM_EN_BASE + 5'(w), 16'h0);
      end
      $display("register map test done");
      for (int i = 0; i < IVM_NSRC; i++)
         one_src(i, 3'($urandom_range(7, 1)));
      one_src(0, 3'h0);
      $display("source mapping test done");
      for (int j = 0; j < 2; j++) begin
         slow <= j[0];
         wr(5'h05, 16'h0003);
         wr(5'h0c, j == 0 ? 16'h0055 : 16'h0062);
         vq.push_back(j == 0 ? {3'h5, 7'd24} : {3'h6, 7'd25});
         pulse_src(17'h000c0);
         repeat (8) @(posedge sys_clk);
         rd(IVM_LAST_ADDR, j == 0 ? 16'h0018 : 16'h0019);
         rd(IVM_STAT_ADDR, j == 0 ? 16'h0098 : 16'h0099);
         wr(5'h01, 16'h0);
      end
      $display("arbitration test done");
      wr(IVM_EN_BASE, 16'h0001);
      wr(IVM_PRIO_BASE, 16'h0001);
      pwr_sleep <= 1'b1;
      pwr_cmd <= 1'b1;
      @(posedge sys_clk);
      pwr_cmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check("sleep", 2'b11, {cpu_halt, clk_stop});
      wdt_timeout <= 1'b1;
      @(posedge sys_clk);
      wdt_timeout <= 1'b0;
      @(posedge sys_clk);
      check("wake", 3'b100, {wake, cpu_halt, clk_stop});
      pwr_sleep <= 1'b0;
      pwr_cmd <= 1'b1;
      @(posedge sys_clk);
      pwr_cmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check("idle", 2'b10, {cpu_halt, clk_stop});
      vq.push_back({3'h1, 7'd8});
      pulse_src(17'h00001);
      // The flag lands one edge after the pulse, and wake shows one edge after that
      @(posedge sys_clk);
      check("wake", 3'b100, {wake, cpu_halt, clk_stop});
      repeat (3) @(posedge sys_clk);
      wr(IVM_FLAG_BASE, 16'h0);
      // A vector or read that never showed up leaves its note behind
      check("open notes", 32'h0, vq.size() + rq.size());
      $display("power test done");
      close_out();
   end
endmodule
